//--- verilog/dmagc_defines.svh
/*
 Constants of the DMA global control block: register offsets, field
 positions, reset values and control table geometry.
 Assumes it is included by bare name from the modules and the bench.
*/
`ifndef DMAGC_DEFINES_SVH
`define DMAGC_DEFINES_SVH

// Register byte offsets on the AXI4-Lite port
`define DMAGC_OFS_CFG     8'h00
`define DMAGC_OFS_BASE    8'h04
`define DMAGC_OFS_ALTBASE 8'h08
`define DMAGC_OFS_TSIZE   8'h0c
`define DMAGC_OFS_ERRST   8'h10
`define DMAGC_OFS_ERRCLR  8'h14
`define DMAGC_OFS_ISTAT   8'h18
`define DMAGC_OFS_IEN     8'h1c
`define DMAGC_OFS_ICLR    8'h20

// Field positions
`define DMAGC_CFG_EN      0
`define DMAGC_CFG_ALT     1
`define DMAGC_INT_ERR     0
`define DMAGC_INT_DONE    1

// Reset values
`define DMAGC_CFG_RST     2'h0
`define DMAGC_BASE_RST    22'h000000
`define DMAGC_IEN_RST     2'h0

// Table geometry: alignment bits, channel count, structure size
`define DMAGC_ALIGN_BITS  10
`define DMAGC_NUM_CH      32
`define DMAGC_STRUCT_B    16
`define DMAGC_HALF_B      32'h00000200
`define DMAGC_FULL_B      32'h00000400

// AXI responses
`define DMAGC_RESP_OKAY   2'h0
`define DMAGC_RESP_SLVERR 2'h2

`endif

//--- verilog/dmagc_pkg.sv
/*
 Types shared by the DMA global control modules.
 Assumes dmagc_defines.svh is on the include path.
*/
package dmagc_pkg;
    // Table fetch sequencer states
    typedef enum logic [0:0] {
        DMAGC_IDLE = 1'b0,
        DMAGC_BUSY = 1'b1
    } dmagc_state_e;
endpackage : dmagc_pkg

//--- verilog/dmagc_fetch.sv
/*
 Control table fetch sequencer: turns a channel word request into one
 read on the system memory bus at the table address.
 Assumes mem_ack is a one-cycle pulse answering a held mem_req.
*/
`timescale 1ns/1ps
`include "dmagc_defines.svh"
module dmagc_fetch
    import dmagc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic        enable,
    // Table geometry
    input  wire logic [31:0] base,
    input  wire logic        alt_use,
    // Request side
    input  wire logic        req,
    input  wire logic [4:0]  ch,
    input  wire logic        alt,
    input  wire logic [1:0]  word,
    output logic             ready_r,
    output logic             done_r,
    output logic             err_r,
    output logic [31:0]      data_r,
    // Memory side
    output logic             mem_req_r,
    output logic [31:0]      mem_addr_r,
    input  wire logic        mem_ack,
    input  wire logic        mem_err,
    input  wire logic [31:0] mem_rdata
);

    dmagc_state_e state_r;   // Sequencer state
    logic [31:0]  addr_nxt;  // Table address of the request
    logic         take;      // Request accepted this cycle

    // Alternates never touched while alternate use is off
    assign addr_nxt = base
        + ((alt & alt_use) ? `DMAGC_HALF_B : 32'h0)
        + {23'h0, ch, 4'h0}
        + {28'h0, word, 2'h0};
    assign take = enable & ready_r & req;

    ////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r    <= DMAGC_IDLE;
            ready_r    <= 1'b0;
            done_r     <= 1'b0;
            err_r      <= 1'b0;
            data_r     <= 32'h0;
            mem_req_r  <= 1'b0;
            mem_addr_r <= 32'h0;
        end else if (ce) begin
            done_r <= 1'b0;
            err_r  <= 1'b0;
            case (state_r)
                DMAGC_IDLE: begin
                    ready_r <= enable & ~take;
                    if (take) begin
                        mem_req_r  <= 1'b1;
                        mem_addr_r <= addr_nxt;
                        state_r    <= DMAGC_BUSY;
                    end
                end
                DMAGC_BUSY: begin
                    if (!enable) begin
                        // Abort: drop the bus at once, no result
                        mem_req_r <= 1'b0;
                        state_r   <= DMAGC_IDLE;
                    end else if (mem_ack) begin
                        mem_req_r <= 1'b0;
                        data_r    <= mem_rdata;
                        done_r    <= ~mem_err;
                        err_r     <= mem_err;
                        ready_r   <= 1'b1;
                        state_r   <= DMAGC_IDLE;
                    end
                end
                default: begin
                    mem_req_r <= 1'b0;
                    state_r   <= DMAGC_IDLE;
                end
            endcase
        end
    end

endmodule : dmagc_fetch

//--- verilog/dmagc_top.sv
/*
 DMA global control: master enable, control table base, alternate
 half base, table size, error status and clear, interrupt status,
 enable and clear, behind an AXI4-Lite slave, plus the table fetcher.
 Assumes one clock aclk, synchronous active-low reset, and that
 channel engines outside use the fetch port to read their structures.
*/
`timescale 1ns/1ps
`include "dmagc_defines.svh"
module dmagc_top
    import dmagc_pkg::*;
(
    // Clock, reset, clock enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Channel engine fetch port
    input  wire logic        fetch_req,
    input  wire logic [4:0]  fetch_ch,
    input  wire logic        fetch_alt,
    input  wire logic [1:0]  fetch_word,
    output logic             fetch_ready,
    output logic             fetch_done,
    output logic [31:0]      fetch_data,
    // System memory bus
    output logic             mem_req,
    output logic [31:0]      mem_addr,
    input  wire logic        mem_ack,
    input  wire logic        mem_err,
    input  wire logic [31:0] mem_rdata,
    // Status outputs
    output logic             dma_active,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction : lane_merge

    // Offset decode shared by reads and writes
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == `DMAGC_OFS_CFG)     | (a == `DMAGC_OFS_BASE)  |
               (a == `DMAGC_OFS_ALTBASE) | (a == `DMAGC_OFS_TSIZE) |
               (a == `DMAGC_OFS_ERRST)   | (a == `DMAGC_OFS_ERRCLR)|
               (a == `DMAGC_OFS_ISTAT)   | (a == `DMAGC_OFS_IEN)   |
               (a == `DMAGC_OFS_ICLR);
    endfunction : is_mapped

    ////////////////////////////////////////////////////////////////////
    // State

    logic [1:0]  cfg_r;        // Master enable and alternate use
    logic [21:0] base_hi_r;    // Table base above the alignment bits
    logic [1:0]  istat_r;      // Sticky events: error, fetch done
    logic [1:0]  ien_r;        // Interrupt enables
    logic        irq_r;        // Registered interrupt level
    // Write channel capture
    logic        awready_r;
    logic        wready_r;
    logic        aw_have_r;    // Address held, waiting for data
    logic        w_have_r;     // Data held, waiting for address
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    // Read channel
    logic        arready_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    ////////////////////////////////////////////////////////////////////
    // Derived table values

    wire [31:0] base_full = {base_hi_r, 10'h0};
    wire [31:0] alt_base  = base_full + `DMAGC_HALF_B;
    // Footprint doubles once alternate structures are in use
    wire [31:0] tbl_size  = cfg_r[`DMAGC_CFG_ALT] ?
                            `DMAGC_FULL_B : `DMAGC_HALF_B;
    wire        enabled   = cfg_r[`DMAGC_CFG_EN];

    ////////////////////////////////////////////////////////////////////
    // Write decode

    wire aw_hs  = s_axi_awvalid & awready_r;
    wire w_hs   = s_axi_wvalid & wready_r;
    wire b_hs   = bvalid_r & s_axi_bready;
    wire wr_go  = aw_have_r & w_have_r & ~bvalid_r;
    wire wr_map = is_mapped(aw_addr_r);
    wire wr_cfg  = wr_go & (aw_addr_r == `DMAGC_OFS_CFG);
    wire wr_base = wr_go & (aw_addr_r == `DMAGC_OFS_BASE);
    wire wr_ien  = wr_go & (aw_addr_r == `DMAGC_OFS_IEN);
    wire wr_eclr = wr_go & (aw_addr_r == `DMAGC_OFS_ERRCLR);
    wire wr_iclr = wr_go & (aw_addr_r == `DMAGC_OFS_ICLR);

    wire [31:0] cfg_m  = lane_merge({30'h0, cfg_r}, w_data_r, w_strb_r);
    wire [31:0] base_m = lane_merge(base_full, w_data_r, w_strb_r);
    wire [31:0] ien_m  = lane_merge({30'h0, ien_r}, w_data_r, w_strb_r);

    wire [1:0]  cfg_nxt  = wr_cfg ? cfg_m[1:0] : cfg_r;
    // Only the aligned part is stored
    wire [21:0] base_nxt = wr_base ? base_m[31:10] : base_hi_r;
    wire [1:0]  ien_nxt  = wr_ien ? ien_m[1:0] : ien_r;

    // Clear strobes, byte lane 0 only
    wire        clr_ok   = w_strb_r[0];
    wire [1:0]  eclr_v   = {1'b0, wr_eclr & clr_ok & w_data_r[0]};
    wire [1:0]  iclr_v   = (wr_iclr & clr_ok) ? w_data_r[1:0] : 2'h0;

    ////////////////////////////////////////////////////////////////////
    // Events and interrupt

    logic        f_done;   // Fetch finished cleanly, one cycle
    logic        f_err;    // Fetch answered with bus error, one cycle
    wire  [1:0]  ev_set  = {f_done, f_err};
    // An event in the clearing cycle survives the clear
    wire  [1:0]  istat_nxt = (istat_r & ~(eclr_v | iclr_v)) | ev_set;
    wire         irq_nxt   = |(istat_nxt & ien_nxt);

    ////////////////////////////////////////////////////////////////////
    // Read decode

    wire ar_hs = s_axi_arvalid & arready_r;
    wire r_hs  = rvalid_r & s_axi_rready;
    wire [7:0] ra = s_axi_araddr;
    wire [31:0] rd_val =
        (ra == `DMAGC_OFS_CFG)     ? {30'h0, cfg_r}           :
        (ra == `DMAGC_OFS_BASE)    ? base_full                :
        (ra == `DMAGC_OFS_ALTBASE) ? alt_base                 :
        (ra == `DMAGC_OFS_TSIZE)   ? tbl_size                 :
        (ra == `DMAGC_OFS_ERRST)   ? {31'h0, istat_r[`DMAGC_INT_ERR]} :
        (ra == `DMAGC_OFS_ISTAT)   ? {30'h0, istat_r}         :
        (ra == `DMAGC_OFS_IEN)     ? {30'h0, ien_r}           :
        32'h0;                       // Clear registers read zero
    wire [1:0] rd_resp = is_mapped(ra) ? `DMAGC_RESP_OKAY :
                                         `DMAGC_RESP_SLVERR;

    ////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r     <= `DMAGC_CFG_RST;
            base_hi_r <= `DMAGC_BASE_RST;
            ien_r     <= `DMAGC_IEN_RST;
            istat_r   <= 2'h0;
            irq_r     <= 1'b0;
        end else if (ce) begin
            cfg_r     <= cfg_nxt;
            base_hi_r <= base_nxt;
            ien_r     <= ien_nxt;
            istat_r   <= istat_nxt;
            irq_r     <= irq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Write channels: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            aw_addr_r <= 8'h0;
            w_data_r  <= 32'h0;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `DMAGC_RESP_OKAY;
        end else if (ce) begin
            if (aw_hs) begin
                aw_addr_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
                awready_r <= 1'b0;
            end
            if (w_hs) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
                wready_r <= 1'b0;
            end
            if (wr_go) begin
                // Unmapped offsets write nothing and report it
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_map ? `DMAGC_RESP_OKAY :
                                      `DMAGC_RESP_SLVERR;
                aw_have_r <= 1'b0;
                w_have_r  <= 1'b0;
            end
            if (b_hs) begin
                // Reopen both channels only after the response
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read channel: data registered one edge after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0;
            rresp_r   <= `DMAGC_RESP_OKAY;
        end else if (ce) begin
            if (ar_hs) begin
                rdata_r   <= rd_val;
                rresp_r   <= rd_resp;
                rvalid_r  <= 1'b1;
                arready_r <= 1'b0;
            end else if (r_hs) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Table fetcher, stopped whenever the master enable is low

    logic        f_ready;
    logic [31:0] f_data;
    logic        m_req;
    logic [31:0] m_addr;

    dmagc_fetch u_fetch (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .ce         (ce),
        .enable     (enabled),
        .base       (base_full),
        .alt_use    (cfg_r[`DMAGC_CFG_ALT]),
        .req        (fetch_req),
        .ch         (fetch_ch),
        .alt        (fetch_alt),
        .word       (fetch_word),
        .ready_r    (f_ready),
        .done_r     (f_done),
        .err_r      (f_err),
        .data_r     (f_data),
        .mem_req_r  (m_req),
        .mem_addr_r (m_addr),
        .mem_ack    (mem_ack),
        .mem_err    (mem_err),
        .mem_rdata  (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////
    // Outputs, each a flip-flop here or in the fetcher

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign fetch_ready   = f_ready;
    assign fetch_done    = f_done;
    assign fetch_data    = f_data;
    assign mem_req       = m_req;
    assign mem_addr      = m_addr;
    assign dma_active    = cfg_r[`DMAGC_CFG_EN];
    assign irq           = irq_r;

endmodule : dmagc_top

//--- bench/dmagc_sva.sv
/*
 Checker for dmagc_top: fetch, memory bus and register bus timing.
 Assumes one clock aclk and a synchronous active-low aresetn.
*/
`timescale 1ns/1ps
module dmagc_chk (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus answers
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    // Fetch port
    input wire logic        fetch_req,
    input wire logic [4:0]  fetch_ch,
    input wire logic [1:0]  fetch_word,
    input wire logic        fetch_ready,
    input wire logic        fetch_done,
    // Memory bus and status
    input wire logic        mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic        mem_ack,
    input wire logic        mem_err,
    input wire logic        dma_active
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    // Base low bits are zero, so offset bits come from the request alone
    property p_take;
        fetch_req && fetch_ready && dma_active |=> mem_req && !fetch_ready &&
            mem_addr[8:0] == {$past(fetch_ch), $past(fetch_word), 2'b00};
    endproperty
    a_take: assert property (p_take)
        else $error("fetch address or start wrong");
    // Three idle cycles allow the disable to drain a pending request
    property p_idle;
        (!dma_active) [*3] |-> !mem_req && !fetch_ready && !fetch_done;
    endproperty
    a_idle: assert property (p_idle)
        else $error("activity while disabled");
    property p_hold;
        mem_req && !mem_ack |=> $stable(mem_addr) && (mem_req || !dma_active);
    endproperty
    a_hold: assert property (p_hold)
        else $error("memory request not held");
    property p_done;
        mem_req && mem_ack && !mem_err && dma_active |=> fetch_done;
    endproperty
    a_done: assert property (p_done)
        else $error("no done after good answer");
    property p_err;
        mem_req && mem_ack && mem_err |=> !fetch_done && !mem_req;
    endproperty
    a_err: assert property (p_err)
        else $error("done after bus error");
    property p_cause;
        fetch_done |-> $past(mem_ack) && !$past(mem_err) && !mem_req;
    endproperty
    a_cause: assert property (p_cause)
        else $error("done without an answer");
    ////////////////////////////////////////////////////////////////////////
    // Register bus: answers come on time and stand until taken
    property p_rd;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd: assert property (p_rd)
        else $error("read answer late");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold)
        else $error("read data dropped");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold)
        else $error("write answer dropped");
endmodule : dmagc_chk

bind dmagc_top dmagc_chk u_chk (.*);

//--- bench/dmagc_mem_model.sv
/*
 System memory model holding the channel control table.
 Assumes the design holds mem_req until one mem_ack pulse.
*/
`timescale 1ns/1ps
module dmagc_mem_model (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Request from the design
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    // Bench controls: answer delay, error answer
    input  wire logic [7:0]  lat,
    input  wire logic        err_in,
    // Answer to the design
    output logic             mem_ack,
    output logic             mem_err,
    output logic [31:0]      mem_rdata
);
    logic [7:0]  wait_r;   // Cycles spent on this request
    logic [31:0] noise_r;  // Filler pattern
    ////////////////////////////////////////////////////////////////////////
    // Table word is the inverted address; between answers the lines
    // carry changing filler, so sampling out of turn shows up
    always_ff @(posedge aclk) begin
        noise_r   <= noise_r + 32'h9e3779b9;
        mem_ack   <= 1'b0;
        mem_err   <= noise_r[0];
        mem_rdata <= noise_r;
        if (!aresetn) begin
            wait_r  <= 8'h00;
            noise_r <= 32'h00000001;
        end else if (mem_req && !mem_ack) begin
            // Answer after the chosen delay
            if (wait_r >= lat) begin
                mem_ack   <= 1'b1;
                mem_err   <= err_in;
                mem_rdata <= ~mem_addr;
                wait_r    <= 8'h00;
            end else begin
                wait_r <= wait_r + 8'h01;
            end
        end else begin
            // Dropped request restarts the delay
            wait_r <= 8'h00;
        end
    end
endmodule : dmagc_mem_model

//--- bench/dma_global_control_test.sv
/*
 Bench for dmagc_top: registers, table fetch, error interrupt, disable.
 Assumes dmagc_mem_model on the memory bus and the bound checker.
*/
`timescale 1ns/1ps
`include "dmagc_defines.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("MISMATCH %0t got %h exp %h", $time, g, e); \
    end end
module dma_global_control_test;
    localparam logic [1:0] rsp_ok = `DMAGC_RESP_OKAY;
    localparam logic [1:0] rsp_err = `DMAGC_RESP_SLVERR;
    // Bench-driven inputs
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, err_in = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, lat = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, base_v = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic fetch_req = 1'b0, fetch_alt = 1'b0, alt_v = 1'b0;
    logic [4:0] fetch_ch = 5'h00;
    logic [1:0] fetch_word = 2'h0;
    // Design and memory model outputs
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, fetch_ready, fetch_done, mem_req, mem_ack;
    logic mem_err, dma_active, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, fetch_data, mem_addr, mem_rdata;
    int bad_count = 0;
    int num_checks = 0;

    always #2.5 aclk = ~aclk;

    dmagc_top dut (.*);
    dmagc_mem_model u_mem (.*);
    ////////////////////////////////////////////////////////////////////////
    // Write one word; response ready is raised late to exercise holding
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            s_axi_bready <= s_axi_bvalid && !s_axi_bready;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 60);
        `CHK(s_axi_bvalid, 1'b1)
        `CHK(s_axi_bresp, r)
    endtask : wr
    // Read one word and compare data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            s_axi_rready <= s_axi_rvalid && !s_axi_rready;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 60);
        `CHK(s_axi_rdata, d)
        `CHK(s_axi_rresp, r)
    endtask : rd
    // One table fetch; address and word worked out from the geometry
    task automatic fetch(input logic [4:0] c, input logic a,
                         input logic [1:0] w, input logic e);
        logic [31:0] x;
        int n;
        x = base_v + ((a && alt_v) ? 32'h200 : 32'h0) + {c, 4'h0} + {w, 2'b00};
        n = 0;
        @(posedge aclk);
        fetch_ch   <= c;
        fetch_alt  <= a;
        fetch_word <= w;
        err_in     <= e;
        fetch_req  <= 1'b1;
        do begin @(posedge aclk); n++; end while (!fetch_ready && n < 50);
        fetch_req <= 1'b0;
        do begin @(posedge aclk); n++; end while (!mem_req && n < 100);
        `CHK(mem_addr, x)
        do begin @(posedge aclk); n++; end while (mem_req && n < 200);
        `CHK(fetch_done, !e)
        if (!e) `CHK(fetch_data, ~x)
    endtask : fetch
    ////////////////////////////////////////////////////////////////////////
    // Reset values of the register file
    task automatic t_reset;
        `CHK(dma_active, 1'b0)
        rd(`DMAGC_OFS_CFG, 32'h0, rsp_ok);
        rd(`DMAGC_OFS_BASE, 32'h0, rsp_ok);
        rd(`DMAGC_OFS_TSIZE, `DMAGC_HALF_B, rsp_ok);
        rd(`DMAGC_OFS_IEN, 32'h0, rsp_ok);
        rd(`DMAGC_OFS_ISTAT, 32'h0, rsp_ok);
    endtask : t_reset
    // Base alignment, upper half, table size, odd addresses
    task automatic t_base;
        wr(`DMAGC_OFS_CFG, 32'h1, rsp_ok);
        wr(`DMAGC_OFS_BASE, 32'hffffffff, rsp_ok);
        rd(`DMAGC_OFS_BASE, 32'hfffffc00, rsp_ok);
        wr(`DMAGC_OFS_ALTBASE, 32'h0, rsp_ok);
        rd(`DMAGC_OFS_ALTBASE, 32'hfffffe00, rsp_ok);
        wr(`DMAGC_OFS_CFG, 32'h3, rsp_ok);
        rd(`DMAGC_OFS_TSIZE, `DMAGC_FULL_B, rsp_ok);
        rd(8'h24, 32'h0, rsp_err);
        wr(8'h24, 32'h1, rsp_err);
        base_v = 32'h20001c00;
        alt_v  = 1'b1;
        wr(`DMAGC_OFS_BASE, base_v, rsp_ok);
    endtask : t_base
    // Prompt and slow fetches, alternate on and off, done interrupt
    task automatic t_fetch;
        fetch(5'd0, 1'b0, 2'd0, 1'b0);
        lat <= 8'd3;
        fetch(5'd31, 1'b1, 2'd3, 1'b0);
        wr(`DMAGC_OFS_CFG, 32'h1, rsp_ok);
        alt_v = 1'b0;
        fetch(5'd5, 1'b1, 2'd1, 1'b0);
        rd(`DMAGC_OFS_ISTAT, 32'h2, rsp_ok);
        `CHK(irq, 1'b0)
        wr(`DMAGC_OFS_IEN, 32'h2, rsp_ok);
        `CHK(irq, 1'b1)
        wr(`DMAGC_OFS_ICLR, 32'h2, rsp_ok);
        rd(`DMAGC_OFS_ISTAT, 32'h0, rsp_ok);
        `CHK(irq, 1'b0)
    endtask : t_fetch
    // Bus error: status, interrupt, handler-style clear
    task automatic t_err;
        wr(`DMAGC_OFS_IEN, 32'h1, rsp_ok);
        fetch(5'd2, 1'b0, 2'd2, 1'b1);
        // Error event lands in status one edge after the fetch ends
        @(posedge aclk);
        `CHK(irq, 1'b1)
        rd(`DMAGC_OFS_ERRST, 32'h1, rsp_ok);
        wr(`DMAGC_OFS_ERRCLR, 32'h1, rsp_ok);
        rd(`DMAGC_OFS_ERRST, 32'h0, rsp_ok);
        `CHK(irq, 1'b0)
    endtask : t_err
    // Disable idle, disable mid-fetch, then work again once enabled
    task automatic t_dis;
        wr(`DMAGC_OFS_CFG, 32'h0, rsp_ok);
        fetch_req <= 1'b1;
        repeat (8) begin
            @(posedge aclk);
            `CHK(fetch_ready | mem_req, 1'b0)
        end
        fetch_req <= 1'b0;
        wr(`DMAGC_OFS_CFG, 32'h1, rsp_ok);
        lat <= 8'd40;
        fetch_req <= 1'b1;
        do @(posedge aclk); while (!fetch_ready);
        fetch_req <= 1'b0;
        wr(`DMAGC_OFS_CFG, 32'h0, rsp_ok);
        repeat (8) begin
            @(posedge aclk);
            `CHK(fetch_done, 1'b0)
        end
        `CHK(mem_req, 1'b0)
        lat <= 8'd0;
        wr(`DMAGC_OFS_CFG, 32'h1, rsp_ok);
        fetch(5'd9, 1'b0, 2'd1, 1'b0);
    endtask : t_dis
    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // Main sequence
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_base();
        t_fetch();
        t_err();
        t_dis();
        end_of_test();
    end
    // Watchdog: tests need well under 2000 cycles
    initial begin
        #50000;
        bad_count++;
        end_of_test();
    end
endmodule : dma_global_control_test
